// ### ocr_otp_readout.sv
// serial slave for reading the one-time-programmable fuse word
// assumes the master makes the serial clock and obeys the low and pulse times
// Functional notes
// [R1] fuse word readable in every mode
// [R2] 188 bits, cell n at bit 187-n
// [R3] bits 187 and 186 read zero
// [R4] bit 185 reads one, next two reserved
// [R5] bits 182..163 four sign-magnitude trims
// [R6] bits 162..119 four 11-bit gain coefficients
// [R7] gain coefficients end 141, 130, 119
// [R8] bits 118..75 four auxiliary factors
// [R9] no start detection while slave drives data
// [R10] master low over 300 ns, pulse 2 us
// [R11] master low over 1.5 core periods
// [R12] first bit after start selects direction
// [R13] four address bits then implied data bits
// [R14] fuse writes only in programming mode
// [R15] read shifts bit 187 first down to 0
// [R16] drive data line only during read data
`timescale 1ns/100ps
module ocr_otp_readout (
   input  wire logic                        clk_in,
   input  wire logic                        rst_n_in,
   input  wire logic                        sclk_in,
   input  wire logic                        sdat_in,
   output logic                             sdat_out,
   output logic                             sdat_oe_out,
   input  wire logic [ocr_pkg::WORD_W-1:0]  fuse_cells_in,
   input  wire logic                        fuse_programming_mode_in,
   output ocr_pkg::ocr_fuse_type            fuse_fields_out,
   output logic                             wr_valid_out,
   input  wire logic                        wr_ready_in,
   output logic [ocr_pkg::WORD_W-1:0]       wr_data_out,
   output logic                             wr_reject_out,
   output logic                             low_short_out
);
   // pin synchronisers and edge history
   ocr_pkg::ocr_pins_type meta_r;
   ocr_pkg::ocr_pins_type sync_r;
   ocr_pkg::ocr_pins_type prev_r;
   logic                  sclk_rise;
   logic                  sclk_fall;
   logic                  start_seen;
   logic                  abort_seen;

   // transfer state
   ocr_pkg::ocr_state_type st_r;
   ocr_pkg::ocr_state_type st_nxt;
   logic [2:0]                  hcnt_r;
   logic [2:0]                  hcnt_nxt;
   logic [7:0]                  cnt_r;
   logic [7:0]                  cnt_nxt;
   logic                        dir_rd_r;
   logic                        dir_rd_nxt;
   logic [ocr_pkg::ADDR_W-1:0]  addr_r;
   logic [ocr_pkg::ADDR_W-1:0]  addr_nxt;
   logic [ocr_pkg::WORD_W-1:0]  shift_r;
   logic [ocr_pkg::WORD_W-1:0]  shift_nxt;
   logic                        oe_r;
   logic                        oe_nxt;
   logic                        push;
   logic                        reject_r;
   logic                        reject_nxt;
   logic [7:0]                  low_r;
   logic [7:0]                  low_nxt;
   logic                        short_r;
   logic                        short_nxt;
   logic                        fifo_ready;
   logic [ocr_pkg::WORD_W-1:0]  word_nxt;
   logic [ocr_pkg::WORD_W-1:0]  word_r;

   // two flip-flops on both pins plus an edge-history stage; the first stage is never looked at
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_r <= '{sclk: 1'b1, sdat: 1'b1};
         sync_r <= '{sclk: 1'b1, sdat: 1'b1};
         prev_r <= '{sclk: 1'b1, sdat: 1'b1};
      end else begin
         meta_r <= '{sclk: sclk_in, sdat: sdat_in};
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   // data moves while the clock is low, so a data edge with the clock high is a condition
   assign sclk_rise  = sync_r.sclk && !prev_r.sclk;
   assign sclk_fall  = !sync_r.sclk && prev_r.sclk;
   assign start_seen = sync_r.sclk && prev_r.sclk && prev_r.sdat && !sync_r.sdat;
   assign abort_seen = sync_r.sclk && prev_r.sclk && !prev_r.sdat && sync_r.sdat;

   // fuse cells map onto the word in reverse; the lock positions are fixed by the factory
   genvar n;
   generate
      for (n = 0; n < ocr_pkg::WORD_W; n++) begin : g_map
         if (ocr_pkg::WORD_W - 1 - n == ocr_pkg::LOCK_POS_A ||
             ocr_pkg::WORD_W - 1 - n == ocr_pkg::LOCK_POS_B) begin : g_zero
            assign word_nxt[ocr_pkg::WORD_W-1-n] = 1'b0; // R3
         end else if (ocr_pkg::WORD_W - 1 - n == ocr_pkg::LOCK_POS_C) begin : g_one
            assign word_nxt[ocr_pkg::WORD_W-1-n] = 1'b1; // R4
         end else begin : g_cell
            assign word_nxt[ocr_pkg::WORD_W-1-n] = fuse_cells_in[n]; // R2
         end
      end
   endgenerate

   // the word is re-registered every cycle so reads always see the array
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         word_r <= '0;
      end else begin
         word_r <= word_nxt;
      end
   end

   // field view of the same word: trims, gain and auxiliary spans
   assign fuse_fields_out = ocr_pkg::ocr_fuse_type'(word_r); // R5 R6 R7 R8

   // transfer sequencer
   always_comb begin
      st_nxt     = st_r;
      hcnt_nxt   = hcnt_r;
      cnt_nxt    = cnt_r;
      dir_rd_nxt = dir_rd_r;
      addr_nxt   = addr_r;
      shift_nxt  = shift_r;
      oe_nxt     = oe_r;
      push       = 1'b0;
      reject_nxt = 1'b0;
      if (st_r != ocr_pkg::ST_READ && start_seen) begin
         // start restarts any transfer that is not a read
         st_nxt   = ocr_pkg::ST_HDR;
         hcnt_nxt = 3'h0;
         oe_nxt   = 1'b0;
      end else if (st_r != ocr_pkg::ST_READ && abort_seen) begin
         st_nxt = ocr_pkg::ST_IDLE;
      end else begin
         unique case (st_r)
            ocr_pkg::ST_IDLE,
            ocr_pkg::ST_SKIP: begin
               oe_nxt = 1'b0;
            end
            ocr_pkg::ST_HDR: begin
               if (sclk_rise) begin
                  hcnt_nxt = hcnt_r + 3'h1;
                  if (hcnt_r == 3'h0) begin
                     dir_rd_nxt = sync_r.sdat; // R12
                  end else begin
                     addr_nxt = {addr_r[ocr_pkg::ADDR_W-2:0], sync_r.sdat}; // R13
                  end
                  if (hcnt_r == ocr_pkg::HDR_LAST) begin
                     cnt_nxt = 8'h00;
                     // only the fuse word length is known here; others are left alone
                     if ({addr_r[ocr_pkg::ADDR_W-2:0], sync_r.sdat} != ocr_pkg::ADDR_FUSE) begin
                        st_nxt = ocr_pkg::ST_SKIP;
                     end else if (dir_rd_r) begin
                        st_nxt    = ocr_pkg::ST_READ; // R1
                        shift_nxt = word_r;
                     end else begin
                        st_nxt = ocr_pkg::ST_WRITE;
                     end
                  end
               end
            end
            ocr_pkg::ST_READ: begin
               // conditions are ignored here; the pin echoes our own drive
               if (sclk_fall) begin // R9
                  if (!oe_r) begin
                     oe_nxt = 1'b1; // R16
                  end else if (cnt_r == ocr_pkg::WORD_LAST) begin
                     oe_nxt = 1'b0; // R16
                     st_nxt = ocr_pkg::ST_IDLE;
                  end else begin
                     cnt_nxt   = cnt_r + 8'h01;
                     shift_nxt = {shift_r[ocr_pkg::WORD_W-2:0], 1'b0}; // R15
                  end
               end
            end
            ocr_pkg::ST_WRITE: begin
               if (sclk_rise) begin
                  shift_nxt = {shift_r[ocr_pkg::WORD_W-2:0], sync_r.sdat};
                  cnt_nxt   = cnt_r + 8'h01;
                  if (cnt_r == ocr_pkg::WORD_LAST) begin
                     st_nxt = ocr_pkg::ST_IDLE;
                     // a full buffer refuses the write just as a locked mode does
                     if (fuse_programming_mode_in && fifo_ready) begin
                        push = 1'b1; // R14
                     end else begin
                        reject_nxt = 1'b1; // R14
                     end
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_r     <= ocr_pkg::ST_IDLE;
         hcnt_r   <= 3'h0;
         cnt_r    <= 8'h00;
         dir_rd_r <= 1'b0;
         addr_r   <= 4'h0;
         shift_r  <= '0;
         oe_r     <= 1'b0;
         reject_r <= 1'b0;
      end else begin
         st_r     <= st_nxt;
         hcnt_r   <= hcnt_nxt;
         cnt_r    <= cnt_nxt;
         dir_rd_r <= dir_rd_nxt;
         addr_r   <= addr_nxt;
         shift_r  <= shift_nxt;
         oe_r     <= oe_nxt;
         reject_r <= reject_nxt;
      end
   end

   assign sdat_oe_out   = oe_r;
   assign sdat_out      = shift_r[ocr_pkg::WORD_W-1];
   assign wr_reject_out = reject_r;

   // low-phase watch: a short low during a read risks a wrong bit
   always_comb begin
      low_nxt   = low_r;
      short_nxt = 1'b0;
      if (sync_r.sclk || st_r != ocr_pkg::ST_READ) begin
         low_nxt = ocr_pkg::LOW_CNT_RST;
      end else if (low_r != 8'hFF) begin
         low_nxt = low_r + 8'h01;
      end
      if (sclk_rise && st_r == ocr_pkg::ST_READ && oe_r &&
          low_r < 8'(ocr_pkg::LOW_MIN_CYC)) begin
         short_nxt = 1'b1; // R10 R11
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         low_r   <= ocr_pkg::LOW_CNT_RST;
         short_r <= 1'b0;
      end else begin
         low_r   <= low_nxt;
         short_r <= short_nxt;
      end
   end

   assign low_short_out = short_r;

   // accepted fuse writes wait here for the programming logic
   ocr_fifo #(
      .WIDTH (ocr_pkg::WORD_W),
      .DEPTH (ocr_pkg::FIFO_DEPTH)
   ) u_wr_fifo (
      .clk_in        (clk_in),
      .rst_n_in      (rst_n_in),
      .in_valid_in   (push),
      .in_ready_out  (fifo_ready),
      .in_data_in    ({shift_r[ocr_pkg::WORD_W-2:0], sync_r.sdat}),
      .out_valid_out (wr_valid_out),
      .out_ready_in  (wr_ready_in),
      .out_data_out  (wr_data_out)
   );

   // helper count of bits driven during one read
   logic [8:0] drv_r;
   logic [8:0] drv_nxt;
   always_comb begin
      drv_nxt = drv_r;
      if (!oe_r) begin
         drv_nxt = 9'h000;
      end else if (sclk_fall) begin
         drv_nxt = drv_r + 9'h001;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         drv_r <= 9'h000;
      end else begin
         drv_r <= drv_nxt;
      end
   end

   sequence s_hdr_first_high;
      st_r == ocr_pkg::ST_HDR && hcnt_r == 3'h0 && sclk_rise && sync_r.sdat;
   endsequence

   sequence s_read_begin;
      st_r == ocr_pkg::ST_READ && !oe_r && sclk_fall;
   endsequence

   a_oe_read_only: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R16
      sdat_oe_out |-> st_r == ocr_pkg::ST_READ) else $error("data line driven outside read");
   a_lock_zero_bits: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R3
      word_r[ocr_pkg::LOCK_POS_A:ocr_pkg::LOCK_POS_B] == 2'h0) else $error("lock bits not zero");
   a_lock_one_bit: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R4
      $past(rst_n_in) |-> word_r[ocr_pkg::LOCK_POS_C]) else $error("lock bit c not one");
   a_cell_map: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R2
      $past(rst_n_in) |-> word_r[ocr_pkg::GAIN2_LSB] == $past(fuse_cells_in[46]))
      else $error("cell 46 not at bit 141");
   a_first_bit_msb: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R15
      s_read_begin |=> sdat_oe_out && sdat_out == word_r[ocr_pkg::WORD_W-1] || $changed(word_r))
      else $error("read does not start with bit 187");
   a_read_length: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R15
      $fell(sdat_oe_out) |-> $past(drv_r) == 9'h0BB) else $error("read length not 188 bits");
   a_start_ignored: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R9
      st_r == ocr_pkg::ST_READ && start_seen && !sclk_fall |=> st_r == ocr_pkg::ST_READ)
      else $error("start seen during read");
   a_dir_read: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R12
      s_hdr_first_high |=> dir_rd_r) else $error("direction bit lost");
   a_write_guard: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R14
      push |-> fuse_programming_mode_in ##1 !wr_reject_out) else $error("write outside mode");
   a_reject_mode: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R14
      st_r == ocr_pkg::ST_WRITE && sclk_rise && cnt_r == ocr_pkg::WORD_LAST
      && !fuse_programming_mode_in && !start_seen && !abort_seen |=> wr_reject_out)
      else $error("write not rejected");

endmodule // ocr_otp_readout

// ### ocr_pkg.sv
// constants and carrier types for the otp calibration readout block
// assumes a 50 MHz core clock and a serial master that makes the serial clock
package ocr_pkg;

   // register map of the two-wire serial port
   localparam int          ADDR_W        = 4;
   localparam logic [3:0]  ADDR_FUSE     = 4'h5;
   localparam int          WORD_W        = 188;
   localparam logic [7:0]  WORD_LAST     = 8'hBB;   // index of the final data bit
   localparam logic [2:0]  HDR_LAST      = 3'h4;    // direction bit plus four address bits

   // factory-programmed lock positions
   localparam int          LOCK_POS_A    = 187;
   localparam int          LOCK_POS_B    = 186;
   localparam int          LOCK_POS_C    = 185;

   // field spans of the fuse word
   localparam int          TRIM_MSB      = 182;
   localparam int          GAIN_MSB      = 162;
   localparam int          GAIN2_LSB     = 141;
   localparam int          AUX_MSB       = 118;
   localparam int          AUX_LSB       = 75;

   // buffering of accepted fuse writes
   localparam int          FIFO_DEPTH    = 16;

   // timing of the serial clock during fuse reads
   localparam int          CLK_PERIOD_NS = 20;
   localparam int          LOW_MIN_NS    = 300;
   localparam int          PULSE_MIN_NS  = 2000;
   localparam int          LOW_MIN_CYC   = (LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          PULSE_MIN_CYC = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0]  LOW_CNT_RST   = 8'h00;

   // one signed analog trim: sign then magnitude
   typedef struct packed {
      logic       sign;
      logic [3:0] mag;
   } ocr_trim_type;

   // fuse word as seen on the port, most significant field first
   typedef struct packed {
      logic [4:0]        lock;      // fuse_lock_field
      ocr_trim_type      trim_cur;  // analog_trim_field, current source
      ocr_trim_type      trim_amp;  // amplifier offset
      ocr_trim_type      trim_ref;  // reference voltage
      ocr_trim_type      trim_tc;   // temperature coefficient
      logic [3:0][10:0]  gain;      // calibration_coeff_field, [3] is the first
      logic [3:0][10:0]  aux;       // auxiliary factors, [3] is the first
      logic [74:0]       rest;      // cells beyond this block
   } ocr_fuse_type;

   // serial port pins as seen by the core
   typedef struct packed {
      logic sclk;
      logic sdat;
   } ocr_pins_type;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_HDR,
      ST_READ,
      ST_WRITE,
      ST_SKIP
   } ocr_state_type;

endpackage

// ### ocr_fifo.sv
// parameterised first-in first-out buffer with valid and ready on both sides
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/100ps
module ocr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic [WIDTH-1:0]      out_data_out
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0]      wptr_r;
   logic [AW:0]      wptr_nxt;
   logic [AW:0]      rptr_r;
   logic [AW:0]      rptr_nxt;
   logic             push;
   logic             pop;

   // full when the pointers differ only in the wrap bit
   assign in_ready_out  = !((wptr_r[AW] != rptr_r[AW]) && (wptr_r[AW-1:0] == rptr_r[AW-1:0]));
   assign out_valid_out = (wptr_r != rptr_r);
   assign out_data_out  = mem_r[rptr_r[AW-1:0]];
   assign push          = in_valid_in && in_ready_out;
   assign pop           = out_valid_out && out_ready_in;

   // pointer advance
   always_comb begin
      wptr_nxt = push ? wptr_r + 1'b1 : wptr_r;
      rptr_nxt = pop ? rptr_r + 1'b1 : rptr_r;
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wptr_r <= '0;
         rptr_r <= '0;
      end else begin
         wptr_r <= wptr_nxt;
         rptr_r <= rptr_nxt;
      end
   end

   // storage has no reset; only written entries are ever presented
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_r[wptr_r[AW-1:0]] <= in_data_in;
      end
   end

endmodule // ocr_fifo

// ### ocr_mst_model.sv
// serial master model: makes the serial clock and drives or releases the data line
// assumes a pull-up on the data line; paces itself on the core clock
`timescale 1ns/100ps
module ocr_mst_model (
   input  wire logic clk_in,
   output logic      sclk_out,
   output logic      m_d_out,
   output logic      m_oe_out,
   input  wire logic bus_in
);
   int lo_c   = 10;   // low phase in core cycles, above 187.5 ns
   int hi_c   = 7;    // high phase in core cycles, above 120 ns
   int glitch = -1;   // data bit, read or write, at which a stray low pulse is forced

   // idle bus: clock stands high, data released
   initial begin
      sclk_out = 1'h1;
      m_d_out  = 1'h1;
      m_oe_out = 1'h0;
   end

   // every change lands 1 ns after a core clock edge
   task automatic wc(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask

   // one bit: data changes only while the clock is low
   task automatic send(input logic b);
      sclk_out = 1'h0;
      m_d_out  = b;
      wc(lo_c);
      sclk_out = 1'h1;
      wc(hi_c);
   endtask

   // start, direction, address msb first, then n data bits
   task automatic xfer(input logic rd, input logic [3:0] a, input logic [187:0] wd,
                       input int n, output logic [187:0] rdw);
      m_oe_out = 1'h1;
      m_d_out  = 1'h1;
      wc(4);
      m_d_out = 1'h0;
      wc(4);
      send(rd);
      for (int i = 3; i >= 0; i--)
         send(a[i]);
      for (int i = n - 1; i >= 0; i--) begin
         sclk_out = 1'h0;
         if (rd)
            m_oe_out = 1'h0;
         else
            m_d_out = wd[i];
         wc(lo_c);
         rdw[i]   = bus_in;
         sclk_out = 1'h1;
         // a stray low pulse only where a scenario asks for one
         if (i == glitch) begin
            wc(20);
            m_d_out  = 1'h0;
            m_oe_out = 1'h1;
            wc(10);
            m_oe_out = 1'h0;
         end
         wc(hi_c);
      end
      // last fall ends the frame; the line is released while the clock is low
      sclk_out = 1'h0;
      m_oe_out = 1'h0;
      wc(lo_c);
      sclk_out = 1'h1;
      wc(hi_c);
   endtask
endmodule // ocr_mst_model

// ### tb.sv
// self-checking bench for the fuse word readout over the serial port
// assumes the master model paces the serial clock from the core clock
`timescale 1ns/100ps
module tb;
   logic                  clk_in    = 1'h0;
   logic                  rst_n_in;
   logic [187:0]          cells;
   logic                  mode;
   logic                  wr_ready;
   logic                  sclk;
   logic                  m_d;
   logic                  m_oe;
   logic                  sdat_out;
   logic                  oe;
   logic                  bus;
   ocr_pkg::ocr_fuse_type fields;
   logic                  wr_valid;
   logic [187:0]          wr_data;
   logic                  rej;
   logic                  lshort;
   logic [187:0]          exp_w;
   logic [187:0]          rd;
   int                    err_count = 0;
   int                    tests_run = 0;
   int                    oe_cnt    = 0;
   int                    rej_cnt   = 0;
   int                    ls_cnt    = 0;

   always #10 clk_in = ~clk_in;

   // wire level: a driving master wins, then the slave, else the pull-up
   assign bus = m_oe ? m_d : (oe ? sdat_out : 1'h1);

   // running counts of drive cycles and one-cycle pulses
   always @(posedge clk_in) begin
      oe_cnt  <= oe_cnt + int'(oe);
      rej_cnt <= rej_cnt + int'(rej);
      ls_cnt  <= ls_cnt + int'(lshort);
   end

   ocr_otp_readout ocr_otp_readout_i (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .sclk_in(sclk), .sdat_in(bus),
      .sdat_out(sdat_out), .sdat_oe_out(oe), .fuse_cells_in(cells),
      .fuse_programming_mode_in(mode), .fuse_fields_out(fields),
      .wr_valid_out(wr_valid), .wr_ready_in(wr_ready), .wr_data_out(wr_data),
      .wr_reject_out(rej), .low_short_out(lshort)
   );

   ocr_mst_model ocr_mst_model_i (
      .clk_in(clk_in), .sclk_out(sclk), .m_d_out(m_d), .m_oe_out(m_oe), .bus_in(bus)
   );

   task automatic chk(input logic [187:0] s, input logic [187:0] e);
      tests_run++;
      if (s !== e) begin
         err_count++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task automatic wc(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask

   task automatic done(input string s);
      $display("test %s ended, mismatches so far %0d", s, err_count);
   endtask

   task automatic end_sim();
      $display("comparisons %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // cell n lands at bit 187-n; the three top lock positions are fixed
   function automatic logic [187:0] fix(input logic [187:0] c);
      logic [187:0] w;
      for (int n = 0; n < 188; n++)
         w[187 - n] = c[n];
      w[187:185] = 3'h1;
      return w;
   endfunction

   // distinct write words, the index shows up at both ends
   function automatic logic [187:0] wword(input int k);
      return ({47{4'ha}} ^ 188'(k)) ^ (188'(k) << 180);
   endfunction

   // parallel field view loaded after reset
   task automatic t_fields();
      chk(188'(fields.lock[4:2]), 188'(3'h1));
      chk(188'(fields.trim_cur), 188'(exp_w[182:178]));
      chk(188'(fields.trim_tc), 188'(exp_w[167:163]));
      chk(188'(fields.gain[3]), 188'(exp_w[162:152]));
      chk(188'(fields.gain[2]), 188'(exp_w[151:141]));
      chk(188'(fields.gain[0]), 188'(exp_w[129:119]));
      chk(188'(fields.aux[3]), 188'(exp_w[118:108]));
      chk(188'(fields.aux[0]), 188'(exp_w[85:75]));
      chk(fields, exp_w);
      done("fields");
   endtask

   // slow read; lo under 15 cycles must raise the short-low flag
   task automatic t_read(input logic md, input int lo, input int gl);
      int ls0;
      ls0  = ls_cnt;
      mode = md;
      ocr_mst_model_i.lo_c   = lo;
      ocr_mst_model_i.hi_c   = 101;
      ocr_mst_model_i.glitch = gl;
      ocr_mst_model_i.xfer(1'h1, ocr_pkg::ADDR_FUSE, '0, 188, rd);
      chk(rd, exp_w);
      chk(188'(ls_cnt != ls0), 188'(lo < 15));
      chk(188'(oe), 188'h0);
      done("read");
   endtask

   // read of an address this block does not serve leaves the line alone
   task automatic t_other();
      int o0;
      o0 = oe_cnt;
      ocr_mst_model_i.lo_c   = 10;
      ocr_mst_model_i.hi_c   = 7;
      ocr_mst_model_i.glitch = -1;
      ocr_mst_model_i.xfer(1'h1, 4'h3, '0, 20, rd);
      chk(188'(oe_cnt - o0), 188'h0);
      chk(188'(rd[19:0]), 188'(20'hf_ffff));
      done("other");
   endtask

   task automatic t_write(input logic md, input logic [187:0] w, input logic rj);
      int r0;
      int o0;
      r0   = rej_cnt;
      o0   = oe_cnt;
      mode = md;
      ocr_mst_model_i.xfer(1'h0, ocr_pkg::ADDR_FUSE, w, 188, rd);
      chk(188'(rej_cnt - r0), 188'(rj));
      chk(188'(oe_cnt - o0), 188'h0);
   endtask

   // a write outside programming mode is refused and never buffered
   task automatic t_locked();
      t_write(1'h0, wword(99), 1'h1);
      chk(188'(wr_valid), 188'h0);
      done("locked");
   endtask

   // a data rise with the clock high abandons a write: nothing buffered, nothing refused
   task automatic t_abort();
      ocr_mst_model_i.glitch = 100;
      t_write(1'h1, wword(7), 1'h0);
      ocr_mst_model_i.glitch = -1;
      chk(188'(wr_valid), 188'h0);
      done("abort");
   endtask

   // fill the write buffer until it refuses, then drain it in order
   task automatic t_fill();
      for (int k = 0; k < 16; k++)
         t_write(1'h1, wword(k), 1'h0);
      t_write(1'h1, wword(16), 1'h1);
      for (int k = 0; k < 16; k++) begin
         chk(188'(wr_valid), 188'h1);
         chk(wr_data, wword(k));
         wr_ready = 1'h1;
         wc(1);
         wr_ready = 1'h0;
         wc(3);
      end
      chk(188'(wr_valid), 188'h0);
      done("fill");
   endtask

   initial begin
      rst_n_in = 1'h0;
      // a 47-bit period, so a field slipped by a few bits still shows
      cells    = {4{47'h234_5678_9ab3}};
      mode     = 1'h0;
      wr_ready = 1'h0;
      exp_w    = fix(cells);
      wc(2);
      chk(188'(oe), 188'h0);
      rst_n_in = 1'h1;
      wc(4);
      t_fields();
      t_read(1'h0, 16, 103);
      t_read(1'h1, 10, -1);
      t_other();
      t_locked();
      t_abort();
      t_fill();
      end_sim();
   end

   // hang guard, some 7 percent above the expected run of about 108,000 cycles
   initial begin
      #2300000;
      err_count++;
      end_sim();
   end
endmodule // tb
